/* File: sbc_pkg.sv */
package sbc_pkg;
  // Bus slave register offsets (byte addresses)
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_OPERAND = 8'h04;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0C;
  localparam logic [7:0] OFS_SRC_INDEX = 8'h10;
  localparam logic [7:0] OFS_DEST_INDEX = 8'h14;
  localparam logic [7:0] OFS_ACCUM = 8'h18;
  localparam logic [7:0] OFS_POINTER = 8'h1C;
  localparam logic [7:0] OFS_SEGS = 8'h20;
  localparam logic [7:0] OFS_RESULT = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;
  localparam logic [7:0] OFS_MEMDATA = 8'h2C;
  // Command fields in the command register
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_COND_LSB = 8;
  localparam int CMD_WORD_BIT = 12;
  localparam int CMD_PREFIX_LSB = 13;
  localparam int CMD_OVR_BIT = 15;
  localparam int CMD_OVRSEG_LSB = 16;
  localparam int CMD_RCNT_LSB = 24;
  localparam int CMD_RCNT_CL_BIT = 29;
  // Flag bit positions in the flag register
  localparam int FLG_CARRY = 0;
  localparam int FLG_PARITY = 2;
  localparam int FLG_ZERO = 6;
  localparam int FLG_SIGN = 7;
  localparam int FLG_DIR = 10;
  localparam int FLG_OVF = 11;
  // Reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] RST_FLAGS = 16'h0000;
  // Instruction groups
  localparam logic [7:0] OP_NONE = 8'h00;
  localparam logic [7:0] OP_ROL = 8'h01;
  localparam logic [7:0] OP_ROR = 8'h02;
  localparam logic [7:0] OP_RCL = 8'h03;
  localparam logic [7:0] OP_RCR = 8'h04;
  localparam logic [7:0] OP_MOVE = 8'h10;
  localparam logic [7:0] OP_CMP = 8'h11;
  localparam logic [7:0] OP_SCAN = 8'h12;
  localparam logic [7:0] OP_LOAD = 8'h13;
  localparam logic [7:0] OP_STORE = 8'h14;
  localparam logic [7:0] OP_JCC = 8'h20;
  localparam logic [7:0] OP_JNEAR = 8'h21;
  localparam logic [7:0] OP_JFAR = 8'h22;
  localparam logic [7:0] OP_CNEAR = 8'h23;
  localparam logic [7:0] OP_CFAR = 8'h24;
  localparam logic [7:0] OP_LOOP = 8'h25;
  localparam logic [7:0] OP_LOOPZ = 8'h26;
  localparam logic [7:0] OP_LOOPNZ = 8'h27;
  localparam logic [7:0] OP_BRANCH_ON_ZERO_COUNT = 8'h28;
  localparam logic [7:0] OP_SWINT = 8'h30;
  localparam logic [7:0] OP_NMI = 8'h31;
  localparam logic [7:0] OP_EXTINT = 8'h32;
  // Repeat prefixes
  localparam logic [1:0] PFX_NONE = 2'h0;
  localparam logic [1:0] PFX_REP = 2'h1;
  localparam logic [1:0] PFX_WHILE = 2'h2;
  localparam logic [1:0] PFX_UNTIL = 2'h3;
  // Segment selectors
  localparam logic [1:0] SEG_EXTRA = 2'h0;
  localparam logic [1:0] SEG_CODE = 2'h1;
  localparam logic [1:0] SEG_STACK = 2'h2;
  localparam logic [1:0] SEG_DATA = 2'h3;
  // Stack push step in bytes
  localparam logic [15:0] PUSH_STEP = 16'h0002;
  typedef enum {ST_IDLE, ST_SRC, ST_DST, ST_STEP, ST_PUSH_CS, ST_PUSH_IP, ST_FLUSH} state_t;
endpackage : sbc_pkg

/* File: string_and_branch_control.sv */
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
module string_and_branch_control
  import sbc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hsel,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic mem_req,
  output logic mem_write,
  output logic [1:0] mem_seg,
  output logic [15:0] mem_offset,
  output logic [15:0] mem_wdata,
  output logic mem_word,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  output logic queue_flush,
  output logic inta_cycle,
  input wire logic irq_pending
);
  logic [31:0] cmd_q;
  logic [15:0] operand_q, flags_q, count_q, si_q, di_q, acc_q, ip_q, cs_q, sp_q;
  logic [15:0] result_q, src_data_q;
  logic busy_q, done_q, paused_q, start_q;
  state_t state_q;
  logic irq_s1_q, irq_s2_q;

  // Command decode
  logic [7:0] op;
  logic [3:0] cond;
  logic is_word, override, cnt_from_cl;
  logic [1:0] prefix, ovr_seg;
  logic [4:0] rcount;
  assign op = cmd_q[CMD_OP_LSB +: 8];
  assign cond = cmd_q[CMD_COND_LSB +: 4];
  assign is_word = cmd_q[CMD_WORD_BIT];
  assign prefix = cmd_q[CMD_PREFIX_LSB +: 2];
  assign override = cmd_q[CMD_OVR_BIT];
  assign ovr_seg = cmd_q[CMD_OVRSEG_LSB +: 2];
  assign cnt_from_cl = cmd_q[CMD_RCNT_CL_BIT];
  assign rcount = cnt_from_cl ? count_q[4:0] : cmd_q[CMD_RCNT_LSB +: 5];

  logic cf, zf, sf, of_, pf, df;
  assign cf = flags_q[FLG_CARRY];
  assign zf = flags_q[FLG_ZERO];
  assign sf = flags_q[FLG_SIGN];
  assign of_ = flags_q[FLG_OVF];
  assign pf = flags_q[FLG_PARITY];
  assign df = flags_q[FLG_DIR];

  // Condition table, low bit negates
  logic cond_base, cond_true;
  always_comb begin
    case (cond[3:1])
      3'h0: cond_base = of_;
      3'h1: cond_base = cf;
      3'h2: cond_base = zf;
      3'h3: cond_base = cf | zf;
      3'h4: cond_base = sf;
      3'h5: cond_base = pf;
      3'h6: cond_base = sf ^ of_;
      default: cond_base = (sf ^ of_) | zf;
    endcase
    cond_true = cond_base ^ cond[0];
  end

  // Rotate engine, one bit position per loop pass
  logic [15:0] rot_val;
  logic rot_c, rot_msb;
  always_comb begin
    rot_val = operand_q;
    rot_c = cf;
    rot_msb = 1'b0;
    for (int i = 0; i < 31; i++) begin
      if (i < 32'(rcount)) begin
        rot_msb = is_word ? rot_val[15] : rot_val[7];
        case (op)
          OP_ROL: begin
            rot_val = is_word ? {rot_val[14:0], rot_val[15]} :
                      {8'h00, rot_val[6:0], rot_val[7]};
            rot_c = rot_val[0];
          end
          OP_ROR: begin
            rot_val = is_word ? {rot_val[0], rot_val[15:1]} :
                      {8'h00, rot_val[0], rot_val[7:1]};
            rot_c = is_word ? rot_val[15] : rot_val[7];
          end
          OP_RCL: begin
            rot_val = is_word ? {rot_val[14:0], rot_c} :
                      {8'h00, rot_val[6:0], rot_c};
            rot_c = rot_msb;
          end
          OP_RCR: begin
            rot_msb = rot_val[0];
            rot_val = is_word ? {rot_c, rot_val[15:1]} :
                      {8'h00, rot_c, rot_val[7:1]};
            rot_c = rot_msb;
          end
          default: rot_val = rot_val;
        endcase
      end
    end
  end

  // Index step and short branch target
  logic [15:0] step, disp, next_ip;
  logic is_str, is_match_op, iterate_prefix, stop_match, mem_done;
  assign step = is_word ? 16'h0002 : 16'h0001;
  assign disp = {{8{operand_q[7]}}, operand_q[7:0]};
  assign next_ip = ip_q + disp;
  assign is_str = (op >= OP_MOVE) && (op <= OP_STORE);
  assign is_match_op = (op == OP_CMP) || (op == OP_SCAN);
  assign iterate_prefix = prefix != PFX_NONE;
  assign mem_done = mem_req && mem_ack;
  // Loop count after decrement and the branch decision
  logic [15:0] count_dec;
  logic branch_taken;
  assign count_dec = count_q - 16'h0001;
  always_comb begin
    case (op)
      OP_JCC: branch_taken = cond_true;
      OP_BRANCH_ON_ZERO_COUNT: branch_taken = count_q == 16'h0000;
      OP_LOOP: branch_taken = count_dec != 16'h0000;
      OP_LOOPZ: branch_taken = (count_dec != 16'h0000) && zf;
      default: branch_taken = (count_dec != 16'h0000) && !zf;
    endcase
  end
  // Zero flag from compare of last element
  logic elem_eq;
  assign elem_eq = is_word ? (src_data_q == mem_rdata) :
                   (src_data_q[7:0] == mem_rdata[7:0]);
  assign stop_match = is_match_op && (((prefix == PFX_WHILE) && !elem_eq) ||
                      ((prefix == PFX_UNTIL) && elem_eq));

  // AHB-Lite address phase capture
  logic [7:0] a_q;
  logic w_q, sel_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      a_q <= 8'h00;
      w_q <= 1'b0;
      sel_q <= 1'b0;
    end else if (hready) begin
      a_q <= haddr[7:0];
      w_q <= hwrite;
      sel_q <= hsel && htrans[1];
    end
  end
  logic wr_en;
  assign wr_en = sel_q && w_q;

  // Always ready, always OKAY: the slave never stalls
  always_ff @(posedge clk) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Read mux registered on the address phase so data stands in the data phase
  always_ff @(posedge clk) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        OFS_CMD: hrdata <= cmd_q;
        OFS_OPERAND: hrdata <= {16'h0000, operand_q};
        OFS_FLAGS: hrdata <= {16'h0000, flags_q};
        OFS_COUNT: hrdata <= {16'h0000, count_q};
        OFS_SRC_INDEX: hrdata <= {16'h0000, si_q};
        OFS_DEST_INDEX: hrdata <= {16'h0000, di_q};
        OFS_ACCUM: hrdata <= {16'h0000, acc_q};
        OFS_POINTER: hrdata <= {16'h0000, ip_q};
        OFS_SEGS: hrdata <= {cs_q, sp_q};
        OFS_RESULT: hrdata <= {16'h0000, result_q};
        OFS_STATUS: hrdata <= {29'h0, paused_q, done_q, busy_q};
        OFS_MEMDATA: hrdata <= {16'h0000, src_data_q};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Interrupt request synchroniser
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_s1_q <= 1'b0;
      irq_s2_q <= 1'b0;
    end else begin
      irq_s1_q <= irq_pending;
      irq_s2_q <= irq_s1_q;
    end
  end

  // Command register; a write starts execution when idle
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_q <= 32'h0000_0000;
      operand_q <= RST_WORD;
      start_q <= 1'b0;
    end else begin
      start_q <= wr_en && (a_q == OFS_CMD) && !busy_q;
      if (wr_en && !busy_q && a_q == OFS_CMD) cmd_q <= hwdata;
      if (wr_en && !busy_q && a_q == OFS_OPERAND) operand_q <= hwdata[15:0];
    end
  end

  // Execution sequencer and architectural state
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      paused_q <= 1'b0;
      flags_q <= RST_FLAGS;
      count_q <= RST_WORD;
      si_q <= RST_WORD;
      di_q <= RST_WORD;
      acc_q <= RST_WORD;
      ip_q <= RST_WORD;
      cs_q <= RST_WORD;
      sp_q <= RST_WORD;
      result_q <= RST_WORD;
      src_data_q <= RST_WORD;
      mem_req <= 1'b0;
      mem_write <= 1'b0;
      mem_seg <= SEG_DATA;
      mem_offset <= RST_WORD;
      mem_wdata <= RST_WORD;
      mem_word <= 1'b0;
      queue_flush <= 1'b0;
      inta_cycle <= 1'b0;
    end else begin
      queue_flush <= 1'b0;
      inta_cycle <= 1'b0;
      if (wr_en && !busy_q) begin
        case (a_q)
          OFS_FLAGS: flags_q <= hwdata[15:0];
          OFS_COUNT: count_q <= hwdata[15:0];
          OFS_SRC_INDEX: si_q <= hwdata[15:0];
          OFS_DEST_INDEX: di_q <= hwdata[15:0];
          OFS_ACCUM: acc_q <= hwdata[15:0];
          OFS_POINTER: ip_q <= hwdata[15:0];
          OFS_SEGS: begin
            cs_q <= hwdata[31:16];
            sp_q <= hwdata[15:0];
          end
          default: ;
        endcase
      end
      case (state_q)
        ST_IDLE: begin
          if (start_q) begin
            busy_q <= 1'b1;
            done_q <= 1'b0;
            paused_q <= 1'b0;
            state_q <= ST_STEP;
          end
        end
        ST_STEP: begin
          state_q <= ST_IDLE;
          busy_q <= 1'b0;
          done_q <= 1'b1;
          if (op >= OP_ROL && op <= OP_RCR) begin
            result_q <= rot_val;
            flags_q[FLG_CARRY] <= rot_c;
          end else if (is_str) begin
            if (iterate_prefix && count_q == 16'h0000) begin
              state_q <= ST_IDLE;
            end else if (iterate_prefix && irq_s2_q) begin
              paused_q <= 1'b1;
            end else begin
              busy_q <= 1'b1;
              done_q <= 1'b0;
              paused_q <= 1'b0;
              mem_req <= 1'b1;
              mem_word <= is_word;
              if (op == OP_STORE) begin
                state_q <= ST_DST;
                mem_write <= 1'b1;
                mem_seg <= SEG_EXTRA;
                mem_offset <= di_q;
                mem_wdata <= acc_q;
              end else if (op == OP_SCAN) begin
                state_q <= ST_DST;
                src_data_q <= acc_q;
                mem_write <= 1'b0;
                mem_seg <= SEG_EXTRA;
                mem_offset <= di_q;
              end else begin
                state_q <= ST_SRC;
                mem_write <= 1'b0;
                mem_seg <= override ? ovr_seg : SEG_DATA;
                mem_offset <= si_q;
              end
            end
          end else if (op == OP_JCC || op == OP_BRANCH_ON_ZERO_COUNT || op >= OP_LOOP && op <= OP_LOOPNZ) begin
            if (op >= OP_LOOP && op <= OP_LOOPNZ) count_q <= count_dec;
            if (branch_taken) begin
              ip_q <= next_ip;
              queue_flush <= 1'b1;
            end
          end else if (op == OP_JNEAR || op == OP_JFAR) begin
            ip_q <= operand_q;
            if (op == OP_JFAR) cs_q <= count_q;
            queue_flush <= 1'b1;
          end else if (op == OP_CNEAR || op == OP_CFAR) begin
            busy_q <= 1'b1;
            done_q <= 1'b0;
            state_q <= (op == OP_CFAR) ? ST_PUSH_CS : ST_PUSH_IP;
            sp_q <= sp_q - PUSH_STEP;
            mem_req <= 1'b1;
            mem_write <= 1'b1;
            mem_word <= 1'b1;
            mem_seg <= SEG_STACK;
            mem_offset <= sp_q - PUSH_STEP;
            mem_wdata <= (op == OP_CFAR) ? cs_q : ip_q;
          end else if (op >= OP_SWINT && op <= OP_EXTINT) begin
            inta_cycle <= (op == OP_EXTINT);
            queue_flush <= 1'b1;
          end
        end
        ST_SRC: if (mem_done) begin
          src_data_q <= mem_rdata;
          si_q <= df ? si_q - step : si_q + step;
          if (op == OP_LOAD) begin
            acc_q <= is_word ? mem_rdata : {acc_q[15:8], mem_rdata[7:0]};
            mem_req <= 1'b0;
            state_q <= ST_FLUSH;
          end else begin
            state_q <= ST_DST;
            mem_seg <= SEG_EXTRA;
            mem_offset <= di_q;
            mem_write <= (op == OP_MOVE);
            mem_wdata <= mem_rdata;
          end
        end
        ST_DST: if (mem_done) begin
          mem_req <= 1'b0;
          mem_write <= 1'b0;
          di_q <= df ? di_q - step : di_q + step;
          if (is_match_op) flags_q[FLG_ZERO] <= elem_eq;
          state_q <= ST_FLUSH;
          if (iterate_prefix) count_q <= count_q - 16'h0001;
          if (iterate_prefix && !stop_match && count_q != 16'h0001) state_q <= ST_STEP;
        end
        ST_PUSH_CS: if (mem_done) begin
          state_q <= ST_PUSH_IP;
          sp_q <= sp_q - PUSH_STEP;
          mem_offset <= sp_q - PUSH_STEP;
          mem_wdata <= ip_q;
        end
        ST_PUSH_IP: if (mem_done) begin
          mem_req <= 1'b0;
          mem_write <= 1'b0;
          ip_q <= operand_q;
          if (op == OP_CFAR) cs_q <= count_q;
          queue_flush <= 1'b1;
          state_q <= ST_FLUSH;
        end
        ST_FLUSH: begin
          state_q <= ST_IDLE;
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule : string_and_branch_control

/* File: sbc_checker.sv */
module sbc_checker
  import sbc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hsel,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic mem_req,
  input wire logic mem_write,
  input wire logic [1:0] mem_seg,
  input wire logic [15:0] mem_offset,
  input wire logic [15:0] mem_wdata,
  input wire logic mem_word,
  input wire logic mem_ack,
  input wire logic queue_flush,
  input wire logic inta_cycle
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Bus slave never stalls and never errors; unmapped reads return zero
  slave_ready_a: assert property (hreadyout)
    else $error("slave ready dropped");
  slave_okay_a: assert property (!hresp)
    else $error("slave answered with error");
  unmapped_zero_a: assert property (hsel && hready && htrans[1] && !hwrite &&
    haddr[7:0] > OFS_MEMDATA |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  // Request holds until the far side answers
  req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_seg)
    && $stable(mem_offset))
    else $error("request address moved before answer");
  req_qual_a: assert property (mem_req && !mem_ack |=> $stable(mem_write)
    && $stable(mem_wdata) && $stable(mem_word))
    else $error("request qualifiers moved before answer");
  // Writes go to extra segment, or stack for pushes
  write_seg_a: assert property (mem_req && mem_write |->
    mem_seg == SEG_EXTRA || mem_seg == SEG_STACK)
    else $error("write to a wrong segment");
  flush_pulse_a: assert property (queue_flush |=> !queue_flush)
    else $error("flush longer than one cycle");
  ack_pulse_a: assert property (inta_cycle |=> !inta_cycle)
    else $error("acknowledge longer than one cycle");

  cover property (mem_req && mem_ack && mem_write);
  cover property (queue_flush);
  cover property (inta_cycle);
endmodule : sbc_checker

bind string_and_branch_control sbc_checker i_chk (.clk, .rst, .haddr, .htrans, .hwrite,
  .hsel, .hready, .hrdata, .hreadyout, .hresp, .mem_req, .mem_write, .mem_seg,
  .mem_offset, .mem_wdata, .mem_word, .mem_ack, .queue_flush, .inta_cycle);

/* File: sbc_mem.sv */
module sbc_mem (
  input wire logic clk,
  input wire logic rst,
  input wire logic mem_req,
  input wire logic mem_write,
  input wire logic [1:0] mem_seg,
  input wire logic [15:0] mem_offset,
  input wire logic [15:0] mem_wdata,
  input wire logic mem_word,
  output logic mem_ack = 1'b0,
  output logic [15:0] mem_rdata = 16'h5A5A
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [logic [17:0]];
  logic [34:0] log_q [$];
  int lat = 0;
  int wt = 0;
  logic [17:0] a;

  // Unwritten bytes read as a fixed filler
  function automatic logic [7:0] rd(logic [17:0] x);
    return mem.exists(x) ? mem[x] : 8'hEE;
  endfunction : rd

  // Answer after lat wait cycles; read data changes every idle cycle
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (!rst && mem_req && !mem_ack) begin
      if (wt < lat) begin
        wt <= wt + 1;
      end else begin
        wt <= 0;
        mem_ack <= 1'b1;
        a = {mem_seg, mem_offset};
        log_q.push_back({mem_write, mem_seg, mem_offset, mem_wdata});
        if (mem_write) begin
          mem[a] = mem_wdata[7:0];
          if (mem_word)
            mem[a + 18'h1] = mem_wdata[15:8];
        end
        mem_rdata <= {mem_word ? rd(a + 18'h1) : 8'h00, rd(a)};
      end
    end
  end
endmodule : sbc_mem

/* File: tb.sv */
module tb;
  import sbc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hsel = 1'b1;
  logic irq_pending = 1'b0;
  wire logic hready;
  logic [31:0] hrdata, q;
  logic hreadyout, hresp, mem_req, mem_write, mem_word, mem_ack, queue_flush, inta_cycle;
  logic [1:0] mem_seg;
  logic [15:0] mem_offset, mem_wdata, mem_rdata;
  int failures = 0;
  int checked = 0;
  int f0, fl_n = 0, ia_n = 0;
  int psh [4] = '{0, 0, 1, 2};
  logic [15:0] pat [4] = '{16'h0000, 16'h08C5, 16'h0080, 16'h0841};

  // 200 MHz
  always #2.5 clk = ~clk;
  // One slave, so its ready is the bus ready
  assign hready = hreadyout;
  // Count transfer flushes and acknowledge cycles
  always @(posedge clk) begin
    fl_n <= fl_n + int'(queue_flush === 1'b1);
    ia_n <= ia_n + int'(inta_cycle === 1'b1);
  end

  string_and_branch_control i_dut (.clk, .rst, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hsel, .hready, .hrdata, .hreadyout, .hresp, .mem_req, .mem_write, .mem_seg,
    .mem_offset, .mem_wdata, .mem_word, .mem_ack, .mem_rdata, .queue_flush, .inta_cycle,
    .irq_pending);
  sbc_mem i_mem (.clk, .rst, .mem_req, .mem_write, .mem_seg, .mem_offset, .mem_wdata,
    .mem_word, .mem_ack, .mem_rdata);

  task automatic print_verdict();
    if (failures == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  task automatic chk(input string n, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Next edge with ready high, bounded
  task automatic edge_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (hready !== 1'b1) begin
      failures++;
      print_verdict();
    end
  endtask : edge_rdy

  // One single-word transfer: address phase, then data phase
  task automatic xf(input logic [7:0] a, input logic w, input logic [31:0] d,
                    output logic [31:0] r);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    edge_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    edge_rdy();
    r = hrdata;
  endtask : xf

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xf(a, 1'b1, d, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    xf(a, 1'b0, 32'h0, r);
  endtask : rd

  // Busy shows one cycle after the command lands
  task automatic poll();
    int n;
    n = 0;
    repeat (3) @(posedge clk);
    do begin
      rd(OFS_STATUS, q);
      n++;
    end while (!(q[1] === 1'b1 && q[0] === 1'b0) && n < 300);
    if (q[1:0] !== 2'b10) begin
      failures++;
      print_verdict();
    end
  endtask : poll

  task automatic run(input logic [31:0] c);
    wr(OFS_CMD, c);
    poll();
  endtask : run

  function automatic logic [31:0] mk(logic [7:0] op, logic w, logic [1:0] p, logic o,
                                     logic [1:0] s);
    return {14'h0, s, o, p, w, 4'h0, op};
  endfunction : mk

  // Expected outcome of a condition code
  function automatic logic ct(logic [3:0] c, logic [15:0] f);
    logic cf, zf, sf, of, r;
    cf = f[FLG_CARRY];
    zf = f[FLG_ZERO];
    sf = f[FLG_SIGN];
    of = f[FLG_OVF];
    case (c[3:1])
      3'h0: r = of;
      3'h1: r = cf;
      3'h2: r = zf;
      3'h3: r = cf | zf;
      3'h4: r = sf;
      3'h5: r = f[FLG_PARITY];
      3'h6: r = sf ^ of;
      default: r = (sf ^ of) | zf;
    endcase
    return r ^ c[0];
  endfunction : ct

  task automatic br(input logic [31:0] c, input logic [15:0] n, f, input logic [7:0] d,
                    input logic t, input logic [15:0] en);
    int f1;
    wr(OFS_FLAGS, {16'h0, f});
    wr(OFS_COUNT, {16'h0, n});
    wr(OFS_POINTER, 32'h1000);
    wr(OFS_OPERAND, {24'h0, d});
    f1 = fl_n;
    run(c);
    rd(OFS_POINTER, q);
    chk("target", t ? 32'h1000 + {{24{d[7]}}, d} : 32'h1000, q);
    chk("flushes", 32'(f1 + int'(t)), 32'(fl_n));
    rd(OFS_COUNT, q);
    chk("count", {16'h0, en}, q);
  endtask : br

  // String move; every element is one read then one write
  task automatic mv(input logic [31:0] c, input logic [15:0] n, f, si, di,
                    input logic [1:0] rs);
    int st;
    logic [34:0] e;
    st = c[CMD_WORD_BIT] ? 2 : 1;
    if (f[FLG_DIR])
      st = -st;
    wr(OFS_FLAGS, {16'h0, f});
    wr(OFS_COUNT, {16'h0, n});
    wr(OFS_SRC_INDEX, {16'h0, si});
    wr(OFS_DEST_INDEX, {16'h0, di});
    i_mem.log_q.delete();
    run(c);
    chk("elements", 32'(2 * int'(n)), 32'(i_mem.log_q.size()));
    foreach (i_mem.log_q[k]) begin
      e = i_mem.log_q[k];
      chk("access", {13'h0, k[0], k[0] ? SEG_EXTRA : rs,
        (k[0] ? di : si) + 16'(st * (k / 2))}, {13'h0, e[34:16]});
    end
    rd(OFS_SRC_INDEX, q);
    chk("src index", {16'h0, si + 16'(st * int'(n))}, q);
    rd(OFS_DEST_INDEX, q);
    chk("dest_index", {16'h0, di + 16'(st * int'(n))}, q);
    rd(OFS_COUNT, q);
    chk("count_reg", 32'h0, q);
  endtask : mv

  // Rotate; carry judged only for through-carry kinds
  task automatic rt(input logic [31:0] c, o, input logic [15:0] f, input logic [31:0] e,
                    input logic cf);
    wr(OFS_FLAGS, {16'h0, f});
    wr(OFS_OPERAND, o);
    run(c);
    rd(OFS_RESULT, q);
    chk("rotate", e, q);
    rd(OFS_FLAGS, q);
    if (c[7:0] >= OP_RCL)
      chk("carry", {31'h0, cf}, {31'h0, q[FLG_CARRY]});
  endtask : rt

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Flags reset value and an unmapped word
    rd(OFS_FLAGS, q);
    chk("flags reset", {16'h0, RST_FLAGS}, q);
    wr(8'h30, 32'hFFFF_FFFF);
    rd(8'h30, q);
    chk("unmapped", 32'h0, q);
    // Every condition code against four flag mixes, then zero-count and loop branches
    for (int p = 0; p < 4; p++)
      for (int c = 0; c < 16; c++)
        br({20'h0, 4'(c), OP_JCC}, 16'h5, pat[p], p[0] ? 8'h80 : 8'h7F,
          ct(4'(c), pat[p]), 16'h5);
    br({24'h0, OP_BRANCH_ON_ZERO_COUNT}, 16'h0, 16'h0, 8'h80, 1'b1, 16'h0);
    br({24'h0, OP_BRANCH_ON_ZERO_COUNT}, 16'h1, 16'h0, 8'h80, 1'b0, 16'h1);
    br({24'h0, OP_LOOP}, 16'h1, 16'h0, 8'h80, 1'b0, 16'h0);
    br({24'h0, OP_LOOP}, 16'h2, 16'h0, 8'h80, 1'b1, 16'h1);
    br({24'h0, OP_LOOPZ}, 16'h2, 16'h0, 8'h80, 1'b0, 16'h1);
    br({24'h0, OP_LOOPZ}, 16'h2, 16'h0040, 8'h7F, 1'b1, 16'h1);
    br({24'h0, OP_LOOPNZ}, 16'h2, 16'h0040, 8'h80, 1'b0, 16'h1);
    br({24'h0, OP_LOOPNZ}, 16'h0, 16'h0, 8'h7F, 1'b1, 16'hFFFF);
    // Jumps and calls: pushes and flushes
    for (int k = 0; k < 4; k++) begin
      wr(OFS_POINTER, 32'h0300);
      wr(OFS_SEGS, 32'h2000_0100);
      i_mem.log_q.delete();
      f0 = fl_n;
      run({24'h0, OP_JNEAR + 8'(k)});
      chk("pushes", 32'(psh[k]), 32'(i_mem.log_q.size()));
      chk("flushes", 32'(f0 + 1), 32'(fl_n));
      if (k > 1)
        chk("pointer pushed", 32'h0300, {16'h0, i_mem.log_q[$][15:0]});
    end
    chk("segment pushed", 32'h2000, {16'h0, i_mem.log_q[0][15:0]});
    // String moves: word up, byte down with override, zero count, offset wrap
    for (int k = 0; k < 6; k++)
      i_mem.mem[{SEG_DATA, 16'h0100 + 16'(k)}] = 8'h10 + 8'(k);
    mv(mk(OP_MOVE, 1, PFX_REP, 0, 0), 16'h3, 16'h0, 16'h0100, 16'h0200, SEG_DATA);
    chk("moved word", 32'h1110, {16'h0, i_mem.log_q[1][15:0]});
    mv(mk(OP_MOVE, 0, PFX_REP, 1, SEG_STACK), 16'h2, 16'h0400, 16'h50, 16'h60, SEG_STACK);
    mv(mk(OP_MOVE, 1, PFX_REP, 0, 0), 16'h0, 16'h0, 16'h0100, 16'h0200, SEG_DATA);
    mv(mk(OP_MOVE, 0, PFX_REP, 0, 0), 16'h2, 16'h0, 16'hFFFF, 16'hFFFE, SEG_DATA);
    // Scans stop early on the zero flag
    for (int k = 0; k < 4; k++)
      i_mem.mem[{SEG_EXTRA, 16'h0080 + 16'(k)}] = (k == 2) ? 8'h42 : 8'h41;
    for (int k = 0; k < 2; k++) begin
      wr(OFS_ACCUM, k ? 32'h42 : 32'h41);
      wr(OFS_FLAGS, 32'h0);
      wr(OFS_COUNT, 32'h4);
      wr(OFS_DEST_INDEX, 32'h80);
      i_mem.log_q.delete();
      run(mk(OP_SCAN, 0, k ? PFX_UNTIL : PFX_WHILE, 0, 0));
      chk("scan reads", 32'h3, 32'(i_mem.log_q.size()));
      rd(OFS_COUNT, q);
      chk("scan count", 32'h1, q);
      rd(OFS_FLAGS, q);
      chk("scan zero", 32'(k), {31'h0, q[FLG_ZERO]});
    end
    // Load and store through the accumulator
    wr(OFS_SRC_INDEX, 32'h0100);
    run(mk(OP_LOAD, 0, PFX_NONE, 0, 0));
    rd(OFS_ACCUM, q);
    chk("loaded", 32'h10, {24'h0, q[7:0]});
    wr(OFS_ACCUM, 32'hBEEF);
    wr(OFS_DEST_INDEX, 32'h0400);
    i_mem.log_q.delete();
    run(mk(OP_STORE, 1, PFX_NONE, 0, 0));
    chk("stored", 32'h0400_BEEF, i_mem.log_q[0][31:0]);
    // Rotates: immediate count, count register, through carry
    rt(mk(OP_ROL, 0, 0, 0, 0) | 32'h0100_0000, 32'h81, 16'h0, 32'h03, 1'b1);
    wr(OFS_COUNT, 32'h4);
    rt(mk(OP_ROR, 1, 0, 0, 0) | 32'h2000_0000, 32'h1, 16'h0, 32'h1000, 1'b0);
    rt(mk(OP_RCL, 0, 0, 0, 0) | 32'h0100_0000, 32'h80, 16'h0, 32'h00, 1'b1);
    rt(mk(OP_RCR, 0, 0, 0, 0) | 32'h0200_0000, 32'h00, 16'h1, 32'h40, 1'b0);
    // Only the external interrupt runs an acknowledge cycle
    for (int k = 0; k < 3; k++) begin
      f0 = ia_n;
      run({24'h0, OP_SWINT + 8'(k)});
      chk("ack cycles", 32'(f0 + int'(k == 2)), 32'(ia_n));
    end
    // Slow memory, interrupt mid-string, then resume
    i_mem.lat = 3;
    wr(OFS_FLAGS, 32'h0);
    wr(OFS_COUNT, 32'h8);
    wr(OFS_SRC_INDEX, 32'h0100);
    wr(OFS_DEST_INDEX, 32'h0200);
    wr(OFS_CMD, mk(OP_MOVE, 1, PFX_REP, 0, 0));
    repeat (20) @(posedge clk);
    irq_pending <= 1'b1;
    poll();
    irq_pending <= 1'b0;
    chk("paused", 32'h1, {31'h0, q[2]});
    rd(OFS_COUNT, q);
    f0 = int'(q);
    chk("mid string", 32'h1, 32'(f0 > 0 && f0 < 8));
    rd(OFS_DEST_INDEX, q);
    chk("resume point", 32'(32'h200 + 2 * (8 - f0)), q);
    repeat (4) @(posedge clk);
    run(mk(OP_MOVE, 1, PFX_REP, 0, 0));
    rd(OFS_COUNT, q);
    chk("resumed count", 32'h0, q);
    rd(OFS_DEST_INDEX, q);
    chk("resumed end", 32'h0210, q);
    print_verdict();
  end
endmodule : tb
